// file: common/gapc_pkg.sv
package gapc_pkg;

    localparam int NPORT = 5;                      // Ports b, c, d, e, f
    localparam int PW    = 16;                     // Register and port width
    localparam int AW    = 16;                     // AXI address width
    localparam int AN_W  = 9;                      // Analog channel pins on port b

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_B_DIRECTION    = 12'h2C6;
    localparam logic [11:0] IDX_B_LEVEL        = 12'h2C8;
    localparam logic [11:0] IDX_B_OUTPUT_LATCH = 12'h2CA;
    localparam logic [11:0] IDX_C_DIRECTION    = 12'h2CC;
    localparam logic [11:0] IDX_C_LEVEL        = 12'h2CE;
    localparam logic [11:0] IDX_C_OUTPUT_LATCH = 12'h2D0;
    localparam logic [11:0] IDX_D_DIRECTION    = 12'h2D2;
    localparam logic [11:0] IDX_D_LEVEL        = 12'h2D4;
    localparam logic [11:0] IDX_D_OUTPUT_LATCH = 12'h2D6;
    localparam logic [11:0] IDX_E_DIRECTION    = 12'h2D8;
    localparam logic [11:0] IDX_E_LEVEL        = 12'h2DA;
    localparam logic [11:0] IDX_E_OUTPUT_LATCH = 12'h2DC;
    localparam logic [11:0] IDX_F_DIRECTION    = 12'h2DE;
    localparam logic [11:0] IDX_F_LEVEL        = 12'h2E0;
    localparam logic [11:0] IDX_F_OUTPUT_LATCH = 12'h2E2;
    localparam logic [11:0] IDX_ANALOG_CFG     = 12'h2E4;

    localparam logic [NPORT-1:0][11:0] IDX_DIRECTION = {
        IDX_F_DIRECTION, IDX_E_DIRECTION, IDX_D_DIRECTION,
        IDX_C_DIRECTION, IDX_B_DIRECTION};
    localparam logic [NPORT-1:0][11:0] IDX_LEVEL = {
        IDX_F_LEVEL, IDX_E_LEVEL, IDX_D_LEVEL, IDX_C_LEVEL, IDX_B_LEVEL};
    localparam logic [NPORT-1:0][11:0] IDX_OUTPUT_LATCH = {
        IDX_F_OUTPUT_LATCH, IDX_E_OUTPUT_LATCH, IDX_D_OUTPUT_LATCH,
        IDX_C_OUTPUT_LATCH, IDX_B_OUTPUT_LATCH};

    // Implemented pins per port, f down to b
    localparam logic [NPORT-1:0][PW-1:0] PIN_MASK = {
        16'h007F, 16'h013F, 16'h000F, 16'hE000, 16'h01FF};
    // Direction after reset: every implemented pin an input
    localparam logic [NPORT-1:0][PW-1:0] DIRECTION_RST = {
        16'h007F, 16'h013F, 16'h000F, 16'hE000, 16'h01FF};
    localparam logic [PW-1:0]   LATCH_RST      = 16'h0000;
    localparam logic [AN_W-1:0] ANALOG_CFG_RST = 9'h000;
    localparam logic [PW-1:0]   ANALOG_MASK    = 16'h01FF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        KIND_DIRECTION,
        KIND_LEVEL,
        KIND_LATCH,
        KIND_ANALOG
    } gapc_kind_type;

    // Result of one address decode
    typedef struct packed {
        logic          hit;
        logic [2:0]    port;
        gapc_kind_type kind;
    } gapc_sel_type;

endpackage : gapc_pkg

// file: src/gapc_port.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - A pin's analog or digital role comes from its analog config bit together with its direction.
// RL2 - Software sets a pin's direction to input before asking for it to be sampled as analog.
// RL3 - An analog pin left as an output presents its own driven level to the converter.
// RL4 - A pin level read returns zero at every pin configured as an analog channel.
// RL5 - A pin configured as a digital input is never routed to the converter.
// RL6 - A read of a port reflects a direction or latch write only two cycles or more later.
// RL7 - Bits with no pin ignore writes and read as zero.
// RL8 - Direction one makes a pin an input with driver off, zero drives it from the latch.
// RL9 - Pin level reads give the sampled pins, and writes to it update the output latch.
// RL10 - Output latch reads give the stored latch contents.
// RL11 - After reset every implemented pin is an input.
// RL12 - Analog zero forcing applies to pin level reads only, never to latch reads.
module gapc_port (
    input  wire logic                                     aclk,          // 200 MHz clock
    input  wire logic                                     aresetn,       // Sync reset, low
    input  wire logic [gapc_pkg::AW-1:0]                  s_axi_awaddr,  // Write address
    input  wire logic                                     s_axi_awvalid, // Write address valid
    output logic                                          s_axi_awready, // Write address ready
    input  wire logic [31:0]                              s_axi_wdata,   // Write data
    input  wire logic [3:0]                               s_axi_wstrb,   // Write strobes
    input  wire logic                                     s_axi_wvalid,  // Write data valid
    output logic                                          s_axi_wready,  // Write data ready
    output logic [1:0]                                    s_axi_bresp,   // Write response
    output logic                                          s_axi_bvalid,  // Write resp valid
    input  wire logic                                     s_axi_bready,  // Write resp ready
    input  wire logic [gapc_pkg::AW-1:0]                  s_axi_araddr,  // Read address
    input  wire logic                                     s_axi_arvalid, // Read address valid
    output logic                                          s_axi_arready, // Read address ready
    output logic [31:0]                                   s_axi_rdata,   // Read data
    output logic [1:0]                                    s_axi_rresp,   // Read response
    output logic                                          s_axi_rvalid,  // Read data valid
    input  wire logic                                     s_axi_rready,  // Read data ready
    input  wire logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] pin_in,    // Pad input levels
    output logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0]  pin_out,       // Pad output levels
    output logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0]  pin_oe,        // Pad driver enables
    output logic [gapc_pkg::AN_W-1:0]                     analog_sel_ext,   // Pin to converter
    output logic [gapc_pkg::AN_W-1:0]                     analog_sel_drive, // Own level sampled
    output logic [gapc_pkg::AN_W-1:0]                     analog_drive_level // Driven level
);

    // Address decode, shared by the read and write paths
    function automatic gapc_pkg::gapc_sel_type reg_decode(input logic [gapc_pkg::AW-1:0] addr);
        gapc_pkg::gapc_sel_type sel;
        sel      = '0;
        sel.kind = gapc_pkg::KIND_DIRECTION;
        if (addr[1:0] == 2'h0 && addr[13:2] == gapc_pkg::IDX_ANALOG_CFG) begin
            sel.hit  = 1'b1;
            sel.kind = gapc_pkg::KIND_ANALOG;
        end
        for (int p = 0; p < gapc_pkg::NPORT; p++) begin
            if (addr[1:0] == 2'h0 && addr[13:2] == gapc_pkg::IDX_DIRECTION[p]) begin
                sel.hit  = 1'b1;
                sel.port = 3'(p);
                sel.kind = gapc_pkg::KIND_DIRECTION;
            end
            if (addr[1:0] == 2'h0 && addr[13:2] == gapc_pkg::IDX_LEVEL[p]) begin
                sel.hit  = 1'b1;
                sel.port = 3'(p);
                sel.kind = gapc_pkg::KIND_LEVEL;
            end
            if (addr[1:0] == 2'h0 && addr[13:2] == gapc_pkg::IDX_OUTPUT_LATCH[p]) begin
                sel.hit  = 1'b1;
                sel.port = 3'(p);
                sel.kind = gapc_pkg::KIND_LATCH;
            end
        end
        if (addr[gapc_pkg::AW-1:14] != '0) begin
            sel.hit = 1'b0;
        end
        return sel;
    endfunction : reg_decode

    logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] direction_r;
    logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] latch_r;
    logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] pin_sample_r;
    logic [gapc_pkg::AN_W-1:0]                    analog_cfg_r;
    logic [gapc_pkg::AW-1:0]                      awaddr_r;
    logic                                         aw_held_r;
    logic [31:0]                                  wdata_r;
    logic [3:0]                                   wstrb_r;
    logic                                         w_held_r;
    logic                                         bvalid_r;
    logic [1:0]                                   bresp_r;
    logic                                         rvalid_r;
    logic [1:0]                                   rresp_r;
    logic [31:0]                                  rdata_r;
    logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] pin_out_r;
    logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] pin_oe_r;
    logic [gapc_pkg::AN_W-1:0]                    sel_ext_r;
    logic [gapc_pkg::AN_W-1:0]                    sel_drive_r;
    logic [gapc_pkg::AN_W-1:0]                    drive_level_r;
    logic                                         wr_fire;
    logic [15:0]                                  wr_merge;
    gapc_pkg::gapc_sel_type                       wr_sel;
    gapc_pkg::gapc_sel_type                       rd_sel;
    logic [gapc_pkg::PW-1:0]                      rd_word;
    logic [gapc_pkg::PW-1:0]                      analog_wide;

    // Each write channel takes one item, then waits for the write to complete; reads wait for rvalid to clear
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    assign wr_fire  = aw_held_r && w_held_r && !bvalid_r;
    assign wr_sel   = reg_decode(awaddr_r);
    assign rd_sel   = reg_decode(s_axi_araddr);
    assign analog_wide = {{(gapc_pkg::PW-gapc_pkg::AN_W){1'b0}}, analog_cfg_r};

    // Byte lanes merged over the current latch, direction or analog config of the addressed register
    always_comb begin
        wr_merge = latch_r[wr_sel.port];
        if (wr_sel.kind == gapc_pkg::KIND_DIRECTION) begin
            wr_merge = direction_r[wr_sel.port];
        end
        if (wr_sel.kind == gapc_pkg::KIND_ANALOG) begin
            wr_merge = analog_wide;
        end
        if (wstrb_r[0]) begin
            wr_merge[7:0] = wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
            wr_merge[15:8] = wdata_r[15:8];
        end
    end

    // Write address held until the write completes; either channel may come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    // Write data and strobes held the same way, independent of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // Write response valid, held until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Unmapped addresses answer with an error and change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_r <= gapc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bresp_r <= wr_sel.hit ? gapc_pkg::RESP_OKAY : gapc_pkg::RESP_SLVERR;
        end
    end

    // Direction and latch registers, one generate lane per port
    for (genvar p = 0; p < gapc_pkg::NPORT; p++) begin : g_port
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                direction_r[p] <= gapc_pkg::DIRECTION_RST[p];   // [RL11]
                latch_r[p]     <= gapc_pkg::LATCH_RST;
            end else if (wr_fire && wr_sel.hit && wr_sel.port == 3'(p)) begin
                unique case (wr_sel.kind)
                    gapc_pkg::KIND_DIRECTION: begin
                        direction_r[p] <= wr_merge & gapc_pkg::PIN_MASK[p];   // [RL7]
                    end
                    gapc_pkg::KIND_LEVEL, gapc_pkg::KIND_LATCH: begin
                        latch_r[p] <= wr_merge & gapc_pkg::PIN_MASK[p];   // [RL9] [RL7]
                    end
                    gapc_pkg::KIND_ANALOG: begin
                    end
                endcase
            end
        end

        // Pad levels follow the latch one cycle later; unpinned bits stay low
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pin_out_r[p] <= '0;
            end else begin
                pin_out_r[p] <= latch_r[p] & gapc_pkg::PIN_MASK[p];   // [RL7]
            end
        end

        // Drivers off at reset so nothing fights the pads; unpinned bits never drive
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pin_oe_r[p] <= '0;
            end else begin
                pin_oe_r[p] <= ~direction_r[p] & gapc_pkg::PIN_MASK[p];   // [RL8]
            end
        end

        // Single sampling stage; pads are taken as synchronous to aclk
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pin_sample_r[p] <= '0;
            end else begin
                pin_sample_r[p] <= pin_in[p] & gapc_pkg::PIN_MASK[p];   // [RL7]
            end
        end
    end

    assign pin_out = pin_out_r;
    assign pin_oe  = pin_oe_r;

    // Analog configuration register, port b channel pins only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_cfg_r <= gapc_pkg::ANALOG_CFG_RST;
        end else if (wr_fire && wr_sel.hit && wr_sel.kind == gapc_pkg::KIND_ANALOG) begin
            analog_cfg_r <= wr_merge[gapc_pkg::AN_W-1:0];
        end
    end

    // Converter routing: external only when analog and input, own level when output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ext_r   <= '0;
            sel_drive_r <= '0;
        end else begin
            sel_ext_r   <= analog_cfg_r & direction_r[0][gapc_pkg::AN_W-1:0];  // [RL1] [RL5]
            sel_drive_r <= analog_cfg_r & ~direction_r[0][gapc_pkg::AN_W-1:0]; // [RL3]
        end
    end

    // Level the converter sees for a driven pin; same lag as the pad outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_level_r <= '0;
        end else begin
            drive_level_r <= latch_r[0][gapc_pkg::AN_W-1:0];   // [RL3]
        end
    end

    assign analog_sel_ext     = sel_ext_r;
    assign analog_sel_drive   = sel_drive_r;
    assign analog_drive_level = drive_level_r;

    // Read mux; level reads see sampled pads, so a fresh write shows two cycles late
    always_comb begin
        rd_word = '0;
        unique case (rd_sel.kind)
            gapc_pkg::KIND_DIRECTION: begin
                rd_word = direction_r[rd_sel.port];
            end
            gapc_pkg::KIND_LEVEL: begin
                rd_word = pin_sample_r[rd_sel.port];   // [RL9] [RL6]
                if (rd_sel.port == 3'h0) begin
                    rd_word = rd_word & ~analog_wide;   // [RL4] [RL12]
                end
            end
            gapc_pkg::KIND_LATCH: begin
                rd_word = latch_r[rd_sel.port];   // [RL10] [RL12]
            end
            gapc_pkg::KIND_ANALOG: begin
                rd_word = analog_wide;
            end
        endcase
        if (!rd_sel.hit) begin
            rd_word = '0;
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Payload loaded only on accept, so it stands while rvalid waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rresp_r <= gapc_pkg::RESP_OKAY;
            rdata_r <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rresp_r <= rd_sel.hit ? gapc_pkg::RESP_OKAY : gapc_pkg::RESP_SLVERR;
            rdata_r <= {16'h0000, rd_word};
        end
    end

endmodule : gapc_port

// file: tb/gapc_pads_model.sv
`timescale 1ns/1ps
// Pads: a driven pin loops back, a released pin follows the outside source
module gapc_pads_model (
    input  wire logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] pin_out,   // Device levels
    input  wire logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] pin_oe,    // Device enables
    input  wire logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] ext_level, // Outside source
    output logic      [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] pin_in     // Level at pad
);
    // Outside source is weaker than an enabled driver, so the driver wins
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gapc_pads_model

// file: tb/gapc_port_monitor.sv
`timescale 1ns/1ps
module gapc_port_monitor (
    input wire logic                                         aclk,               // Clock
    input wire logic                                         aresetn,            // Reset, low
    input wire logic                                         s_axi_bvalid,       // Write resp
    input wire logic                                         s_axi_arvalid,      // Read addr
    input wire logic                                         s_axi_arready,      // Read ready
    input wire logic                                         s_axi_rvalid,       // Read valid
    input wire logic [31:0]                                  s_axi_rdata,        // Read data
    input wire logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] pin_out,            // Pad levels
    input wire logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] pin_oe,             // Pad enables
    input wire logic [gapc_pkg::AN_W-1:0]                    analog_sel_ext,     // External
    input wire logic [gapc_pkg::AN_W-1:0]                    analog_sel_drive,   // Own level
    input wire logic [gapc_pkg::AN_W-1:0]                    analog_drive_level  // Level
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_sel_excl; (analog_sel_ext & analog_sel_drive) == '0; endproperty
    a_sel_excl: assert property (p_sel_excl) else $error("analog selects overlap");
    property p_drv_oe; (analog_sel_drive & ~pin_oe[0][8:0]) == '0; endproperty
    a_drv_oe: assert property (p_drv_oe) else $error("own level sampled on input");
    property p_drv_lvl;
        (analog_drive_level & analog_sel_drive) == (pin_out[0][8:0] & analog_sel_drive);
    endproperty
    a_drv_lvl: assert property (p_drv_lvl) else $error("drive level not latch");
    property p_ext_in; (analog_sel_ext & pin_oe[0][8:0]) == '0; endproperty
    a_ext_in: assert property (p_ext_in) else $error("driven pin routed as input");
    property p_unimpl; ((pin_oe | pin_out) & ~gapc_pkg::PIN_MASK) == '0; endproperty
    a_unimpl: assert property (p_unimpl) else $error("missing pin active");
    property p_rst_in; $rose(aresetn) |-> pin_oe == '0 && analog_sel_ext == '0; endproperty
    a_rst_in: assert property (p_rst_in) else $error("pin driven after reset");
    property p_rd_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_next: assert property (p_rd_next) else $error("read not answered");
    property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == '0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_oe_cause; $changed(pin_oe) |-> $past(s_axi_bvalid); endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("enable moved without write");
endmodule : gapc_port_monitor

bind gapc_port gapc_port_monitor u_mon (.aclk, .aresetn, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .pin_out, .pin_oe, .analog_sel_ext,
    .analog_sel_drive, .analog_drive_level);

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] EXT = 16'hC3A5;
    localparam logic [1:0]  OK  = gapc_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR = gapc_pkg::RESP_SLVERR;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] pin_in, pin_out, pin_oe;
    logic [gapc_pkg::NPORT-1:0][gapc_pkg::PW-1:0] ext_level = {5{EXT}};
    logic [gapc_pkg::AN_W-1:0] analog_sel_ext, analog_sel_drive, analog_drive_level;
    int          mismatches = 0, n_checks = 0, cycles = 0;

    gapc_port DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
        .pin_oe, .analog_sel_ext, .analog_sel_drive, .analog_drive_level);
    gapc_pads_model u_pads (.pin_out, .pin_oe, .ext_level, .pin_in);

    // 200 MHz clock
    initial begin
        forever #2.5 aclk = ~aclk;
    end

    // Byte address of a port register: k 0 direction, 1 level, 2 latch, 3 analog config
    function automatic logic [15:0] ra(input int p, input int k);
        logic [11:0] idx;
        idx = (k == 0) ? gapc_pkg::IDX_DIRECTION[p] : (k == 1) ? gapc_pkg::IDX_LEVEL[p] :
              (k == 2) ? gapc_pkg::IDX_OUTPUT_LATCH[p] : gapc_pkg::IDX_ANALOG_CFG;
        return {2'b00, idx, 2'b00};
    endfunction : ra

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Both channels offered together; ready lines hold high, so no signal moves twice
    task automatic wr(input logic [15:0] addr, input logic [15:0] d, input logic [1:0] er);
        s_axi_awaddr <= addr;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk($sformatf("bresp %h", addr), {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : wr

    task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input logic [1:0] er);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk($sformatf("rdata %h", addr), {16'h0000, exp}, s_axi_rdata);
        chk($sformatf("rresp %h", addr), {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : rd

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // Hang guard, well above the roughly two hundred cycles the tests need
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int p = 0; p < 5; p++) begin
            rd(ra(p, 0), gapc_pkg::PIN_MASK[p], OK);
            rd(ra(p, 2), 16'h0000, OK);
            rd(ra(p, 1), EXT & gapc_pkg::PIN_MASK[p], OK);
        end
        rd(ra(0, 3), 16'h0000, OK);
        $display("test reset_values done");
        // Each port as outputs and back, reading soon after each write
        for (int p = 0; p < 5; p++) begin
            logic [15:0] m;
            m = gapc_pkg::PIN_MASK[p];
            wr(ra(p, 0), 16'h0000, OK);
            wr(ra(p, 2), 16'hFFFF, OK);
            repeat (2) @(posedge aclk);
            rd(ra(p, 1), m, OK);
            chk("pin_oe", {16'h0, m}, {16'h0, pin_oe[p]});
            chk("pin_out", {16'h0, m}, {16'h0, pin_out[p]});
            wr(ra(p, 1), 16'h1234, OK);
            rd(ra(p, 2), 16'h1234 & m, OK);
            wr(ra(p, 0), 16'hFFFF, OK);
            rd(ra(p, 0), m, OK);
            repeat (2) @(posedge aclk);
            rd(ra(p, 1), EXT & m, OK);
            chk("pin_oe", 32'h0, {16'h0, pin_oe[p]});
        end
        $display("test port_io done");
        // Analog channels on port b, first as inputs, then left as outputs
        wr(ra(0, 3), 16'h00F0, OK);
        rd(ra(0, 3), 16'h00F0, OK);
        rd(ra(0, 1), EXT & gapc_pkg::PIN_MASK[0] & ~16'h00F0, OK);
        rd(ra(0, 2), 16'h0034, OK);
        chk("analog_sel_ext", 32'h0F0, {23'h0, analog_sel_ext});
        chk("analog_sel_drive", 32'h0, {23'h0, analog_sel_drive});
        wr(ra(0, 0), 16'h0000, OK);
        repeat (2) @(posedge aclk);
        chk("analog_sel_drive", 32'h0F0, {23'h0, analog_sel_drive});
        chk("analog_sel_ext", 32'h0, {23'h0, analog_sel_ext});
        chk("analog_drive_level", 32'h034, {23'h0, analog_drive_level});
        rd(ra(0, 1), 16'h0004, OK);
        rd(ra(0, 2), 16'h0034, OK);
        $display("test analog done");
        // Upper byte lane only: port e latch keeps its low byte
        s_axi_wstrb <= 4'h2;
        wr(ra(3, 2), 16'hFFFF, OK);
        s_axi_wstrb <= 4'hF;
        rd(ra(3, 2), 16'h0134, OK);
        $display("test byte_lanes done");
        // Unmapped and misaligned places
        rd(16'h0004, 16'h0000, ERR);
        rd(ra(0, 2) + 16'h0001, 16'h0000, ERR);
        wr(16'h0004, 16'hFFFF, ERR);
        $display("test unmapped done");
        end_of_test();
    end
endmodule : testbench
